// ---- hw/frame_irq_pkg.sv ----
package frame_irq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map, as byte offsets on the processor port.
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFS_STATUS    = 8'h24;
	localparam logic [7:0]  OFS_INT_EN    = 8'h28;
	localparam logic [7:0]  OFS_FRAME_IDX = 8'h2c;

	// Field positions shared by the status and enable registers.
	localparam int BIT_PORT_CHANGE = 2;
	localparam int BIT_ROLLOVER    = 3;

	// Reset values of the three registers.
	localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
	localparam logic [31:0] INT_EN_RESET    = 32'h0000_0000;
	localparam logic [31:0] FRAME_IDX_RESET = 32'h0000_0000;

	// Frame index layout: 14 bits, list entry taken from bit 3 upward.
	localparam int IDX_W    = 14;
	localparam int LIST_LSB = 3;
	localparam int LIST_W   = 10;

	// Encodings of the list size field.
	localparam logic [1:0] LIST_1024 = 2'h0;
	localparam logic [1:0] LIST_512  = 2'h1;
	localparam logic [1:0] LIST_256  = 2'h2;

	// Microframe timing at the core clock.
	localparam int CLK_PERIOD_NS     = 10;
	localparam int MICROFRAME_NS     = 125000;
	localparam int MICROFRAME_CYCLES = MICROFRAME_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// One register access from the processor port.
	typedef struct packed {
		logic              cs;
		logic              wr;
		logic              rd;
		logic              dword;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} reg_req_t;

	// Read answer, one cycle after the request.
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} reg_rsp_t;

	// Index bits that take part in the list position for a list size.
	function automatic logic [IDX_W-1:0] list_mask(input logic [1:0] size);
		case (size)
			LIST_512: list_mask = 14'h0fff;
			LIST_256: list_mask = 14'h07ff;
			default: list_mask = 14'h1fff;
		endcase
	endfunction

	// List entry selected by an index value under a list size.
	function automatic logic [LIST_W-1:0] list_entry(
		input logic [IDX_W-1:0] idx,
		input logic [1:0]       size);
		logic [IDX_W-1:0] v;
		v = idx & list_mask(size);
		list_entry = v[IDX_W-2:LIST_LSB];
	endfunction

endpackage

// ---- hw/microframe_timer.sv ----
`timescale 1ns/1ps
module microframe_timer #(
	parameter int TICK_CYCLES = frame_irq_pkg::MICROFRAME_CYCLES
) (
	// Clock and reset.
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// Run control and microframe boundary.
	input  wire logic run_in,
	output logic      tick_out
);

	localparam int CNT_W = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 9) begin : g_chk
		$error("microframe_timer needs at least nine cycles per tick");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} timer_state_t;

	timer_state_t st_r;
	timer_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// The count restarts while stopped, so the first tick after run is
	// always a whole microframe away.
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!run_in) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt == CNT_W'(TICK_CYCLES - 1)) begin
			st_nxt.cnt  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1);
		end
	end

	// Synchronous reset clears the counter.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_out = st_r.tick;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	property p_tick_spacing;
		tick_out |=> !tick_out [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("microframe ticks too close together");

	property p_tick_needs_run;
		tick_out |-> $past(run_in);
	endproperty
	a_tick_needs_run: assert property (p_tick_needs_run)
		else $error("microframe tick while stopped");

endmodule

// ---- hw/frame_index_irq.sv ----
`timescale 1ns/1ps
//
// Contract
// - Set rollover flag when index wraps.
// - Port change on owned port (owner bit clear) sets flag.
// - Force-resume rise sets port change flag.
// - Interrupt when enable and flag both set.
// - Flags record even with enable clear.
// - Rollover interrupt acknowledged by clearing flag.
// - Port change interrupt acknowledged by clearing flag.
// - Advance index once per 125 us.
// - List entry from index bit 3 upward.
// - Index write accepted only while halted.
// - Index write changes subsequent frame number.
// - 14-bit index increments each microframe.
// - Writing one clears flag, zero keeps it.
// - Index advances only while run set.
module frame_index_irq #(
	parameter int NUM_PORTS   = 3,
	parameter int TICK_CYCLES = frame_irq_pkg::MICROFRAME_CYCLES
) (
	// Clock and reset.
	input  wire logic                             mclk_in,
	input  wire logic                             rst_n_in,
	// Processor register port.
	input  wire frame_irq_pkg::reg_req_t          reg_req_in,
	output frame_irq_pkg::reg_rsp_t               reg_rsp_out,
	// Controller state from the command logic.
	input  wire logic                             run_control_bit_in,
	input  wire logic                             halted_indicator_in,
	input  wire logic [1:0]                       list_size_field_in,
	// Port state, one bit per port.
	input  wire logic [NUM_PORTS-1:0]             port_owner_bit_in,
	input  wire logic [NUM_PORTS-1:0]             port_change_in,
	input  wire logic [NUM_PORTS-1:0]             force_resume_bit_in,
	// Frame position and interrupt.
	output logic [frame_irq_pkg::IDX_W-1:0]       microframe_counter_out,
	output logic [frame_irq_pkg::LIST_W-1:0]      list_index_out,
	output logic                                  irq_out
);

	localparam int IW = frame_irq_pkg::IDX_W;
	localparam int LW = frame_irq_pkg::LIST_W;

	if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_chk
		$error("frame_index_irq serves one to sixteen ports");
	end

	typedef struct packed {
		logic                       rollover_flag;
		logic                       port_change_flag;
		logic                       rollover_enable;
		logic                       port_change_enable;
		logic [IW-1:0]              idx;
		logic [LW-1:0]              list_idx;
		logic [NUM_PORTS-1:0]       chg_prev;
		logic [NUM_PORTS-1:0]       resume_prev;
		logic                       irq;
		frame_irq_pkg::reg_rsp_t    rsp;
	} core_state_t;

	core_state_t st_r;
	core_state_t st_nxt;

	logic tick;
	logic wr_status;
	logic wr_int_en;
	logic wr_idx_ok;
	logic rd_hit;
	logic advance;
	logic roll_evt;
	logic port_evt;
	logic resume_evt;
	logic [IW-1:0] mask;

	////////////////////////////////////////////////////////////////////////
	// Microframe boundary source.
	microframe_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_microframe_timer (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.run_in   (run_control_bit_in),
		.tick_out (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Access decode.  A half-word write to the index is dropped, since
	// its effect is undefined and dropping it keeps the count coherent.
	assign wr_status = reg_req_in.cs && reg_req_in.wr &&
		reg_req_in.addr == frame_irq_pkg::OFS_STATUS;
	assign wr_int_en = reg_req_in.cs && reg_req_in.wr &&
		reg_req_in.addr == frame_irq_pkg::OFS_INT_EN;
	assign wr_idx_ok = reg_req_in.cs && reg_req_in.wr &&
		reg_req_in.dword && halted_indicator_in &&
		reg_req_in.addr == frame_irq_pkg::OFS_FRAME_IDX;
	assign rd_hit = reg_req_in.cs && reg_req_in.rd;

	// Event detection.  Change and resume inputs are levels, so only a
	// rise counts; a bit held high does not set the flag again.
	assign mask     = frame_irq_pkg::list_mask(list_size_field_in);
	assign advance  = tick && run_control_bit_in && !wr_idx_ok;
	assign roll_evt = advance && ((st_r.idx & mask) == mask);
	assign port_evt = |(port_change_in & ~st_r.chg_prev &
		~port_owner_bit_in);
	assign resume_evt = |(force_resume_bit_in & ~st_r.resume_prev);

	////////////////////////////////////////////////////////////////////////
	// Next state.  An event in the cycle of a clear wins over the clear,
	// so no event is ever lost to a racing acknowledge.
	always_comb begin
		logic [31:0] rd_data;
		rd_data = 32'h0000_0000;
		st_nxt = st_r;
		st_nxt.chg_prev = port_change_in;
		st_nxt.resume_prev = force_resume_bit_in;

		// Status flags are write-one-to-clear.
		if (wr_status &&
			reg_req_in.wdata[frame_irq_pkg::BIT_ROLLOVER]) begin
			st_nxt.rollover_flag = 1'b0;
		end
		if (wr_status &&
			reg_req_in.wdata[frame_irq_pkg::BIT_PORT_CHANGE]) begin
			st_nxt.port_change_flag = 1'b0;
		end

		// Flags are set whatever the enables say.
		if (roll_evt) begin
			st_nxt.rollover_flag = 1'b1;
		end
		if (port_evt || resume_evt) begin
			st_nxt.port_change_flag = 1'b1;
		end

		// Enable register keeps only its two defined bits.
		if (wr_int_en) begin
			st_nxt.rollover_enable =
				reg_req_in.wdata[frame_irq_pkg::BIT_ROLLOVER];
			st_nxt.port_change_enable =
				reg_req_in.wdata[frame_irq_pkg::BIT_PORT_CHANGE];
		end

		// Frame index: a halted write loads it, a running tick advances.
		if (wr_idx_ok) begin
			st_nxt.idx = reg_req_in.wdata[IW-1:0];
		end else if (advance) begin
			st_nxt.idx = IW'(st_r.idx + 1'b1);
		end
		st_nxt.list_idx = frame_irq_pkg::list_entry(st_nxt.idx,
			list_size_field_in);

		// Registered interrupt follows the flags of the same edge.
		st_nxt.irq =
			(st_nxt.rollover_flag && st_nxt.rollover_enable) ||
			(st_nxt.port_change_flag && st_nxt.port_change_enable);

		// Read mux; unmapped offsets read as zero.
		case (reg_req_in.addr)
			frame_irq_pkg::OFS_STATUS: begin
				rd_data[frame_irq_pkg::BIT_ROLLOVER]    = st_r.rollover_flag;
				rd_data[frame_irq_pkg::BIT_PORT_CHANGE] = st_r.port_change_flag;
			end
			frame_irq_pkg::OFS_INT_EN: begin
				rd_data[frame_irq_pkg::BIT_ROLLOVER]    = st_r.rollover_enable;
				rd_data[frame_irq_pkg::BIT_PORT_CHANGE] =
					st_r.port_change_enable;
			end
			frame_irq_pkg::OFS_FRAME_IDX: begin
				rd_data[IW-1:0] = st_r.idx;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
		st_nxt.rsp.valid = rd_hit;
		st_nxt.rsp.data  = rd_hit ? rd_data : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Controller reset brings every register to its reset value.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// All outputs come straight from the state register.
	assign reg_rsp_out            = st_r.rsp;
	assign microframe_counter_out = st_r.idx;
	assign list_index_out         = st_r.list_idx;
	assign irq_out                = st_r.irq;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	property p_rollover_set;
		roll_evt |=> st_r.rollover_flag && microframe_counter_out ==
			($past(microframe_counter_out) + 14'h0001);
	endproperty
	a_rollover_set: assert property (p_rollover_set)
		else $error("rollover did not set its flag");

	property p_port_change_set;
		port_evt |=> st_r.port_change_flag;
	endproperty
	a_port_change_set: assert property (p_port_change_set)
		else $error("port change missed");

	property p_resume_set;
		resume_evt |=> st_r.port_change_flag;
	endproperty
	a_resume_set: assert property (p_resume_set)
		else $error("force resume missed");

	property p_irq_follows;
		irq_out == ((st_r.rollover_flag && st_r.rollover_enable) ||
			(st_r.port_change_flag && st_r.port_change_enable));
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("interrupt not the OR of enabled flags");

	property p_poll_without_enable;
		!st_r.port_change_enable && port_evt && !irq_out &&
		!roll_evt && !wr_int_en |=>
			st_r.port_change_flag && !irq_out;
	endproperty
	a_poll_without_enable: assert property (p_poll_without_enable)
		else $error("disabled event lost or interrupted");

	property p_rollover_ack;
		irq_out && st_r.rollover_flag && wr_status &&
		reg_req_in.wdata[frame_irq_pkg::BIT_ROLLOVER] && !roll_evt |=>
			!st_r.rollover_flag;
	endproperty
	a_rollover_ack: assert property (p_rollover_ack)
		else $error("rollover acknowledge failed");

	property p_port_ack;
		wr_status && reg_req_in.wdata[frame_irq_pkg::BIT_PORT_CHANGE] &&
		!port_evt && !resume_evt |=> !st_r.port_change_flag;
	endproperty
	a_port_ack: assert property (p_port_ack)
		else $error("port change acknowledge failed");

	property p_zero_keeps;
		st_r.rollover_flag && wr_status &&
		!reg_req_in.wdata[frame_irq_pkg::BIT_ROLLOVER] |=>
			st_r.rollover_flag;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("writing zero cleared a flag");

	property p_list_entry;
		##1 list_index_out == frame_irq_pkg::list_entry(
			microframe_counter_out, $past(list_size_field_in));
	endproperty
	a_list_entry: assert property (p_list_entry)
		else $error("list index does not match the frame index");

	property p_write_halted;
		wr_idx_ok |=> microframe_counter_out == $past(reg_req_in.wdata[13:0]);
	endproperty
	a_write_halted: assert property (p_write_halted)
		else $error("index write not loaded");

	property p_write_refused;
		reg_req_in.cs && reg_req_in.wr && !halted_indicator_in &&
		reg_req_in.addr == frame_irq_pkg::OFS_FRAME_IDX && !tick |=>
			$stable(microframe_counter_out);
	endproperty
	a_write_refused: assert property (p_write_refused)
		else $error("index written while not halted");

	property p_stopped_holds;
		!run_control_bit_in && !wr_idx_ok |=> $stable(microframe_counter_out);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds)
		else $error("index moved while stopped");

	property p_advance;
		advance |=> microframe_counter_out ==
			IW'($past(microframe_counter_out) + 1'b1);
	endproperty
	a_advance: assert property (p_advance)
		else $error("index did not step by one");

	// Scenarios the bench is meant to reach, one cover each.
	c_rollover: cover property (roll_evt ##1 irq_out);
	c_port_irq: cover property ((port_evt || resume_evt) &&
		st_r.port_change_enable);
	c_index_load: cover property (wr_idx_ok ##3 reg_rsp_out.valid);
	c_full_wrap: cover property (advance && &microframe_counter_out);

endmodule

// ---- dv/host_sw_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Software side of the register port: one access at a time, launched just
// after a rising edge and held across the edge that takes it.
module host_sw_model (
	// Clock.
	input  wire logic                    mclk_in,
	// Register port.
	input  wire frame_irq_pkg::reg_rsp_t reg_rsp_in,
	output frame_irq_pkg::reg_req_t      reg_req_out
);

	// The port is idle until the first access.
	initial begin
		reg_req_out = '0;
	end

	// Reserved bits always go out as zero; the block ignores them today, but
	// a driver that sets them would misbehave on a wider register.
	function automatic logic [31:0] keep_mask(input logic [7:0] a);
		if (a == frame_irq_pkg::OFS_FRAME_IDX) begin
			keep_mask = 32'h0000_3fff;
		end else begin
			keep_mask = 32'h0000_000c;
		end
	endfunction

	// Write; the index is written as a full word unless a caller asks not to.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic dw = 1'b1);
		@(posedge mclk_in);
		#1;
		reg_req_out = '{1'b1, 1'b1, 1'b0, dw, a, d & keep_mask(a)};
		@(posedge mclk_in);
		#1;
		reg_req_out = '0;
	endtask

	// Read; the answer is taken in the one cycle it stands.
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic v);
		@(posedge mclk_in);
		#1;
		reg_req_out = '{1'b1, 1'b0, 1'b1, 1'b1, a, 32'h0000_0000};
		@(posedge mclk_in);
		#1;
		reg_req_out = '0;
		v = reg_rsp_in.valid;
		d = reg_rsp_in.data;
	endtask

endmodule

// ---- dv/frame_index_irq_test.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Register-level test of the status, enable and frame index logic.
module frame_index_irq_test;

	// A short microframe keeps the run small; the step counts derive from it.
	localparam int TICK = 16;

	logic                    mclk_in  = 1'b0;
	logic                    rst_n_in = 1'b0;
	frame_irq_pkg::reg_req_t req;
	frame_irq_pkg::reg_rsp_t rsp;
	logic                    run      = 1'b0;
	logic                    halted   = 1'b1;
	logic [1:0]              list_size = 2'h0;
	logic [2:0]              owner    = 3'h0;
	logic [2:0]              change   = 3'h0;
	logic [2:0]              resume   = 3'h0;
	logic [13:0]             idx;
	logic [9:0]              lst;
	logic                    irq;
	int                      mismatches  = 0;
	int                      comparisons = 0;
	logic [31:0]             rdat;
	logic                    rv;
	logic [9:0]              lst_exp [4] = '{10'h3ff, 10'h1ff, 10'h0ff, 10'h3ff};

	// Core clock, 100 MHz.
	always #5 mclk_in = ~mclk_in;

	frame_index_irq #(
		.NUM_PORTS   (3),
		.TICK_CYCLES (TICK)
	) u_frame_index_irq (
		.mclk_in                (mclk_in),
		.rst_n_in               (rst_n_in),
		.reg_req_in             (req),
		.reg_rsp_out            (rsp),
		.run_control_bit_in     (run),
		.halted_indicator_in    (halted),
		.list_size_field_in     (list_size),
		.port_owner_bit_in      (owner),
		.port_change_in         (change),
		.force_resume_bit_in    (resume),
		.microframe_counter_out (idx),
		.list_index_out         (lst),
		.irq_out                (irq)
	);

	host_sw_model u_host_sw_model (
		.mclk_in     (mclk_in),
		.reg_rsp_in  (rsp),
		.reg_req_out (req)
	);

	////////////////////////////////////////////////////////////////////////
	// Compare one value and count it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Read and compare; a missing answer is a mismatch as well.
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		u_host_sw_model.rd(a, rdat, rv);
		check({31'h0, rv}, 32'h0000_0001);
		check(rdat, exp);
	endtask

	// Wait for the next index change, counting edges from the call.
	task automatic step(input int exp_n, input logic [13:0] exp_idx);
		logic [13:0] old;
		int          n;
		old = idx;
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			n++;
		end while (idx === old && n < 100);
		check(32'(n), 32'(exp_n));
		check({18'h0, idx}, {18'h0, exp_idx});
	endtask

	// Single place where the run ends.
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// A hang is cut short well after the two hundred or fewer cycles the tests need.
	initial begin
		#100000;
		mismatches++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (20) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		rchk(frame_irq_pkg::OFS_STATUS, frame_irq_pkg::STATUS_RESET);
		rchk(frame_irq_pkg::OFS_INT_EN, frame_irq_pkg::INT_EN_RESET);
		rchk(frame_irq_pkg::OFS_FRAME_IDX, 32'h0000_0000);
		rchk(8'h30, 32'h0000_0000);
		check({31'h0, irq}, 32'h0);
		u_host_sw_model.wr(frame_irq_pkg::OFS_INT_EN, 32'h0000_000c);
		rchk(frame_irq_pkg::OFS_INT_EN, 32'h0000_000c);
		u_host_sw_model.wr(frame_irq_pkg::OFS_INT_EN, 32'h0000_0000);
		// A change on a port we own is recorded with the enable off.
		change = 3'b001;
		rchk(frame_irq_pkg::OFS_STATUS, 32'h0000_0004);
		check({31'h0, irq}, 32'h0);
		u_host_sw_model.wr(frame_irq_pkg::OFS_STATUS, 32'h0000_0000);
		rchk(frame_irq_pkg::OFS_STATUS, 32'h0000_0004);
		u_host_sw_model.wr(frame_irq_pkg::OFS_STATUS, 32'h0000_0004);
		rchk(frame_irq_pkg::OFS_STATUS, 32'h0000_0000);
		// A change on a port handed away must not count.
		owner = 3'b010;
		change = 3'b011;
		rchk(frame_irq_pkg::OFS_STATUS, 32'h0000_0000);
		// Resume on a suspended port, this time with the enable on.
		u_host_sw_model.wr(frame_irq_pkg::OFS_INT_EN, 32'h0000_0004);
		resume = 3'b100;
		@(posedge mclk_in);
		#1;
		check({31'h0, irq}, 32'h1);
		u_host_sw_model.wr(frame_irq_pkg::OFS_STATUS, 32'h0000_0004);
		check({31'h0, irq}, 32'h0);
		// Index writes that must be refused: half word, then not halted.
		u_host_sw_model.wr(frame_irq_pkg::OFS_FRAME_IDX, 32'h1234, 1'b0);
		check({18'h0, idx}, 32'h0);
		halted = 1'b0;
		u_host_sw_model.wr(frame_irq_pkg::OFS_FRAME_IDX, 32'h1234);
		check({18'h0, idx}, 32'h0);
		halted = 1'b1;
		// List entry for every list size code.
		for (int i = 0; i < 4; i++) begin
			list_size = i[1:0];
			u_host_sw_model.wr(frame_irq_pkg::OFS_FRAME_IDX, 32'h3ff8);
			check({18'h0, idx}, 32'h3ff8);
			check({22'h0, lst}, {22'h0, lst_exp[i]});
		end
		rchk(frame_irq_pkg::OFS_FRAME_IDX, 32'h0000_3ff8);
		// Rollover of a 256-entry list; writes are all done before run.
		list_size = frame_irq_pkg::LIST_256;
		u_host_sw_model.wr(frame_irq_pkg::OFS_FRAME_IDX, 32'h07fe);
		u_host_sw_model.wr(frame_irq_pkg::OFS_INT_EN, 32'h0000_0008);
		halted = 1'b0;
		run = 1'b1;
		step(TICK + 1, 14'h07ff);
		check({31'h0, irq}, 32'h0);
		step(TICK, 14'h0800);
		check({31'h0, irq}, 32'h1);
		check({22'h0, lst}, 32'h0);
		run = 1'b0;
		repeat (40) @(posedge mclk_in);
		#1;
		check({18'h0, idx}, 32'h0800);
		// A zero in the rollover bit must leave that flag standing.
		u_host_sw_model.wr(frame_irq_pkg::OFS_STATUS, 32'h0000_0004);
		check({31'h0, irq}, 32'h1);
		rchk(frame_irq_pkg::OFS_STATUS, 32'h0000_0008);
		u_host_sw_model.wr(frame_irq_pkg::OFS_STATUS, 32'h0000_0008);
		check({31'h0, irq}, 32'h0);
		// The full index wraps from its top value to zero.
		halted = 1'b1;
		list_size = frame_irq_pkg::LIST_1024;
		u_host_sw_model.wr(frame_irq_pkg::OFS_FRAME_IDX, 32'h3fff);
		halted = 1'b0;
		run = 1'b1;
		step(TICK + 1, 14'h0000);
		rchk(frame_irq_pkg::OFS_STATUS, 32'h0000_0008);
		end_of_test();
	end

endmodule
